//--- hdl/fss_regs.svh
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH

// Instruction codes
`define FSS_CMD_REGW      8'h01
`define FSS_CMD_PROG      8'h02
`define FSS_CMD_WPCLR     8'h04
`define FSS_CMD_RDST1     8'h05
`define FSS_CMD_WPSET     8'h06
`define FSS_CMD_RDST2     8'h07
`define FSS_CMD_CLRST     8'h30
`define FSS_CMD_BULK      8'h60
`define FSS_CMD_ESUSP     8'h75
`define FSS_CMD_PSUSP     8'h85
`define FSS_CMD_SECT      8'hD8
`define FSS_CMD_SWRST     8'hF0

// Status byte field positions
`define FSS_BIT_LOCK      7
`define FSS_BIT_PFAIL     6
`define FSS_BIT_EFAIL     5
`define FSS_BIT_GUARD_HI  4
`define FSS_BIT_GUARD_LO  2
`define FSS_BIT_WPL       1
`define FSS_BIT_ACT       0

// Reset and shipped values
`define FSS_GUARD_VOL_RST 3'h7
`define FSS_GUARD_NV_RST  3'h0
`define FSS_LOCK_NV_RST   1'b0

// Timing
`define FSS_CLK_PERIOD_NS 10
`define FSS_REGW_TIME_NS  1000
`define FSS_REGW_CYCLES   ((`FSS_REGW_TIME_NS + `FSS_CLK_PERIOD_NS - 1) / `FSS_CLK_PERIOD_NS)

`endif

//--- hdl/fss_pkg.sv
package fss_pkg;

    typedef enum logic [5:0] {
        FSS_IDLE  = 6'h01,
        FSS_REGW  = 6'h02,
        FSS_PROG  = 6'h04,
        FSS_ERASE = 6'h08,
        FSS_BULK  = 6'h10,
        FSS_HALT  = 6'h20
    } fss_state_t;

    typedef logic [7:0] fss_byte_t;

endpackage

//--- hdl/fss_link_if.sv
`timescale 1ns/1ps
interface fss_link_if;
    import fss_pkg::*;
    fss_byte_t rx_byte;
    logic      rx_valid;
    logic      frame_start;
    logic      frame_end;
    fss_byte_t tx_byte;

    modport shifter (output rx_byte, output rx_valid, output frame_start, output frame_end, input tx_byte);
    modport ctrl    (input rx_byte, input rx_valid, input frame_start, input frame_end, output tx_byte);
endinterface

//--- hdl/fss_shifter.sv
`timescale 1ns/1ps
module fss_shifter (
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  nrst,
    // Serial pins
    input  wire logic  sck,
    input  wire logic  cs_n,
    input  wire logic  si,
    output logic       so,
    output logic       so_oe,
    // Byte side
    fss_link_if.shifter lk
);
    import fss_pkg::*;

    logic [2:0] sck_q;
    logic [2:0] csn_q;
    logic [1:0] si_q;
    logic [2:0] cnt_q;
    logic [7:0] rxsh_q;
    logic [7:0] txsh_q;
    logic [7:0] rxb_q;
    logic       rxv_q;
    logic       fs_q;
    logic       fe_q;
    logic       so_q;
    logic       oe_q;

    // Edges are taken from stages 2 and 3 so stage 1 feeds nothing else
    wire sck_rise = sck_q[1] & ~sck_q[2] & ~csn_q[1];
    wire sck_fall = ~sck_q[1] & sck_q[2] & ~csn_q[1];
    wire cs_fall  = ~csn_q[1] & csn_q[2];
    wire cs_rise  = csn_q[1] & ~csn_q[2];
    wire [7:0] rx_next = {rxsh_q[6:0], si_q[1]};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_q <= 3'h0;
            csn_q <= 3'h7;
            si_q  <= 2'h0;
        end else begin
            sck_q <= {sck_q[1:0], sck};
            csn_q <= {csn_q[1:0], cs_n};
            si_q  <= {si_q[0], si};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= 3'h0;
            rxsh_q <= 8'h00;
            rxb_q  <= 8'h00;
            rxv_q  <= 1'b0;
        end else begin
            rxv_q <= 1'b0;
            if (cs_fall) begin
                cnt_q <= 3'h0;
            end else if (sck_rise) begin
                rxsh_q <= rx_next;
                cnt_q  <= cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    rxb_q <= rx_next;
                    rxv_q <= 1'b1;
                end
            end
        end
    end

    // Mode 0 and 3: data changes on the falling edge, new byte at bit 0
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            txsh_q <= 8'h00;
            so_q   <= 1'b0;
            oe_q   <= 1'b0;
            fs_q   <= 1'b0;
            fe_q   <= 1'b0;
        end else begin
            fs_q <= cs_fall;
            fe_q <= cs_rise;
            oe_q <= ~csn_q[1];
            if (cs_fall) begin
                txsh_q <= 8'h00;
                so_q   <= 1'b0;
            end else if (sck_fall && cnt_q == 3'h0) begin
                so_q   <= lk.tx_byte[7];
                txsh_q <= {lk.tx_byte[6:0], 1'b0};
            end else if (sck_fall) begin
                so_q   <= txsh_q[7];
                txsh_q <= {txsh_q[6:0], 1'b0};
            end
        end
    end

    assign so             = so_q;
    assign so_oe          = oe_q;
    assign lk.rx_byte     = rxb_q;
    assign lk.rx_valid    = rxv_q;
    assign lk.frame_start = fs_q;
    assign lk.frame_end   = fe_q;
endmodule

//--- hdl/fss_status_ctrl.sv
`timescale 1ns/1ps
`include "fss_regs.svh"
// Behaviour
// - Lock plus low pin freezes lock and guards
// - High pin or clear lock allows writes
// - Program failure or protected target sets flag
// - Erase failure or protected sector sets flag
// - Bulk erase protected skip sets no flag
// - Failure flags cleared only by clear or software reset command
// - Nonzero guards reject program/erase in area
// - Guards volatile per select, volatile default ones
// - Bulk erase only with all guards zero
// - Set and clear commands drive permit latch
// - Writes need permit latch set
// - Successful operation clears permit latch
// - Resets clear latch; register write completion clears it too
// - Active flag high through every operation
// - While active only reads, suspends, clear, reset
// - Suspends only during matching array operation
// - Failure keeps device active until cleared
// - Register write command loads lock and guards
// - Lock protection bit freezes guard bits
module fss_status_ctrl #(
    parameter int REGW_CYCLES = `FSS_REGW_CYCLES
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Serial pins
    input  wire logic         sck,
    input  wire logic         cs_n,
    input  wire logic         si,
    input  wire logic         wr_protect_n,
    output logic              so,
    output logic              so_oe,
    // Configuration
    input  wire logic         guard_volatility_select,
    input  wire logic         lock_protection_bit,
    // Array core
    input  wire logic         target_protected,
    input  wire logic         op_done,
    input  wire logic         op_fail,
    input  wire logic         bulk_prot_seen,
    output logic              prog_start,
    output logic              erase_start,
    output logic              bulk_start,
    output logic              erase_suspend,
    output logic              prog_suspend,
    output logic              soft_reset,
    output logic [23:0]       op_addr,
    output fss_pkg::fss_byte_t flash_status_one
);
    import fss_pkg::*;

    fss_link_if lk ();

    fss_shifter u_shift (
        .clock (clock),
        .nrst  (nrst),
        .sck   (sck),
        .cs_n  (cs_n),
        .si    (si),
        .so    (so),
        .so_oe (so_oe),
        .lk    (lk.shifter)
    );

    function automatic logic busy_ok(input fss_byte_t c);
        busy_ok = (c == `FSS_CMD_RDST1) || (c == `FSS_CMD_RDST2) || (c == `FSS_CMD_ESUSP) ||
                  (c == `FSS_CMD_PSUSP) || (c == `FSS_CMD_CLRST) || (c == `FSS_CMD_SWRST);
    endfunction

    fss_state_t state_q;
    fss_state_t state_d;
    logic [1:0] wp_q;
    logic       init_q;
    fss_byte_t  cmd_q;
    logic [2:0] idx_q;
    logic [23:0] addr_q;
    fss_byte_t  wdata_q;
    fss_byte_t  tx_q;
    logic [15:0] tmr_q;
    logic       lock_q;
    logic       lock_d;
    logic [2:0] guard_q;
    logic [2:0] guard_d;
    logic [2:0] nvg_q;
    logic [2:0] nvg_d;
    logic       wpl_q;
    logic       wpl_d;
    logic       pf_q;
    logic       pf_d;
    logic       ef_q;
    logic       ef_d;
    fss_byte_t  stat_q;
    logic       pst_q;
    logic       est_q;
    logic       bst_q;
    logic       esp_q;
    logic       psp_q;
    logic       srs_q;

    // Command decode at the end of the frame
    wire busy     = state_q != FSS_IDLE;
    wire go       = lk.frame_end & (idx_q != 3'h0) & (~busy | busy_ok(cmd_q));
    wire is_regw  = cmd_q == `FSS_CMD_REGW;
    wire is_prog  = cmd_q == `FSS_CMD_PROG;
    wire is_sect  = cmd_q == `FSS_CMD_SECT;
    wire is_bulk  = cmd_q == `FSS_CMD_BULK;
    wire hw_lock  = lock_q & ~wp_q[1];
    wire wpset_ok = go & ~busy & (cmd_q == `FSS_CMD_WPSET);
    wire wpclr_ok = go & ~busy & (cmd_q == `FSS_CMD_WPCLR);
    wire clr_ok   = go & (cmd_q == `FSS_CMD_CLRST);
    wire rst_ok   = go & (cmd_q == `FSS_CMD_SWRST);
    wire regw_ok  = go & ~busy & wpl_q & is_regw & (idx_q >= 3'h2) & ~hw_lock;
    wire prog_ok  = go & ~busy & wpl_q & is_prog & (idx_q >= 3'h5);
    wire sect_ok  = go & ~busy & wpl_q & is_sect & (idx_q >= 3'h4);
    wire bulk_ok  = go & ~busy & wpl_q & is_bulk & (guard_q == 3'h0);
    wire esp_ok   = go & (cmd_q == `FSS_CMD_ESUSP) & (state_q == FSS_ERASE || state_q == FSS_BULK);
    wire psp_ok   = go & (cmd_q == `FSS_CMD_PSUSP) & (state_q == FSS_PROG);
    wire regw_end = (state_q == FSS_REGW) & (tmr_q == 16'h0);
    wire op_end   = op_done & (state_q == FSS_PROG || state_q == FSS_ERASE || state_q == FSS_BULK);
    wire pf_set   = (prog_ok & target_protected) |
                    (op_end & op_fail & (state_q == FSS_PROG));
    wire ef_set   = (sect_ok & target_protected) |
                    (op_end & op_fail & (state_q == FSS_ERASE)) |
                    (op_end & op_fail & (state_q == FSS_BULK) & ~bulk_prot_seen);
    wire vol_rst  = guard_volatility_select;
    wire [2:0] guard_rst = vol_rst ? `FSS_GUARD_VOL_RST : nvg_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wp_q <= 2'h3;
        end else begin
            wp_q <= {wp_q[0], wr_protect_n};
        end
    end

    // Frame bookkeeping
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd_q   <= 8'h00;
            idx_q   <= 3'h0;
            addr_q  <= 24'h0;
            wdata_q <= 8'h00;
        end else if (lk.frame_start) begin
            idx_q <= 3'h0;
        end else if (lk.rx_valid) begin
            idx_q <= (idx_q == 3'h7) ? idx_q : idx_q + 3'h1;
            if (idx_q == 3'h0) begin
                cmd_q <= lk.rx_byte;
            end
            if (idx_q == 3'h1) begin
                wdata_q <= lk.rx_byte;
            end
            if (~busy && (idx_q >= 3'h1) && (idx_q <= 3'h3) && (is_prog || is_sect)) begin
                addr_q <= {addr_q[15:0], lk.rx_byte};
            end
        end
    end

    // Read data stays live so repeated bytes track the status
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_q <= 8'h00;
        end else if (lk.frame_start || idx_q == 3'h0) begin
            tx_q <= 8'h00;
        end else if (cmd_q == `FSS_CMD_RDST1) begin
            tx_q <= stat_q;
        end else begin
            tx_q <= 8'h00;
        end
    end
    assign lk.tx_byte = tx_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            FSS_IDLE: begin
                if (regw_ok) begin
                    state_d = FSS_REGW;
                end else if (prog_ok) begin
                    state_d = target_protected ? FSS_HALT : FSS_PROG;
                end else if (sect_ok) begin
                    state_d = target_protected ? FSS_HALT : FSS_ERASE;
                end else if (bulk_ok) begin
                    state_d = FSS_BULK;
                end
            end
            FSS_REGW: begin
                if (regw_end) begin
                    state_d = FSS_IDLE;
                end
            end
            FSS_PROG, FSS_ERASE, FSS_BULK: begin
                if (op_end) begin
                    state_d = (pf_set || ef_set) ? FSS_HALT : FSS_IDLE;
                end
            end
            FSS_HALT: begin
                if (clr_ok) begin
                    state_d = FSS_IDLE;
                end
            end
            default: state_d = FSS_IDLE;
        endcase
        if (rst_ok) begin
            state_d = FSS_IDLE;
        end
    end

    // Hardware sets win over a clear arriving in the same cycle
    assign pf_d = (pf_q & ~clr_ok & ~rst_ok) | pf_set;
    assign ef_d = (ef_q & ~clr_ok & ~rst_ok) | ef_set;

    assign wpl_d = rst_ok ? 1'b0 :
                   wpset_ok ? 1'b1 :
                   wpclr_ok ? 1'b0 :
                   (regw_end || (op_end && !op_fail)) ? 1'b0 :
                   wpl_q;

    // Guard write is dropped while frozen; the lock bit still loads
    assign lock_d  = regw_end ? wdata_q[`FSS_BIT_LOCK] : lock_q;
    assign guard_d = init_q || rst_ok ? guard_rst :
                     (regw_end && !lock_protection_bit) ?
                     wdata_q[`FSS_BIT_GUARD_HI:`FSS_BIT_GUARD_LO] : guard_q;
    assign nvg_d   = (regw_end && !lock_protection_bit && !vol_rst) ?
                     wdata_q[`FSS_BIT_GUARD_HI:`FSS_BIT_GUARD_LO] : nvg_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= FSS_IDLE;
            init_q  <= 1'b1;
            tmr_q   <= 16'h0;
            lock_q  <= `FSS_LOCK_NV_RST;
            guard_q <= `FSS_GUARD_NV_RST;
            nvg_q   <= `FSS_GUARD_NV_RST;
            wpl_q   <= 1'b0;
            pf_q    <= 1'b0;
            ef_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            init_q  <= 1'b0;
            tmr_q   <= regw_ok ? 16'(REGW_CYCLES - 1) : (tmr_q != 16'h0 ? tmr_q - 16'h1 : tmr_q);
            lock_q  <= lock_d;
            guard_q <= guard_d;
            nvg_q   <= nvg_d;
            wpl_q   <= wpl_d;
            pf_q    <= pf_d;
            ef_q    <= ef_d;
        end
    end

    // Registered outputs toward the core and the status view
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_q <= 8'h00;
            pst_q  <= 1'b0;
            est_q  <= 1'b0;
            bst_q  <= 1'b0;
            esp_q  <= 1'b0;
            psp_q  <= 1'b0;
            srs_q  <= 1'b0;
        end else begin
            stat_q <= {lock_q, pf_q, ef_q, guard_q, wpl_q, busy};
            pst_q  <= prog_ok & ~target_protected;
            est_q  <= sect_ok & ~target_protected;
            bst_q  <= bulk_ok;
            esp_q  <= esp_ok;
            psp_q  <= psp_ok;
            srs_q  <= rst_ok;
        end
    end

    assign prog_start       = pst_q;
    assign erase_start      = est_q;
    assign bulk_start       = bst_q;
    assign erase_suspend    = esp_q;
    assign prog_suspend     = psp_q;
    assign soft_reset       = srs_q;
    assign op_addr          = addr_q;
    assign flash_status_one = stat_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_regw_finish;
        state_q == FSS_REGW ##0 tmr_q == 16'h0;
    endsequence
    sequence s_fail_seen;
        pf_q || ef_q;
    endsequence

    a_hw_lock_hold: assert property (hw_lock && !rst_ok && !init_q |=> $stable(lock_q))
        else $error("lock bit changed under hardware lock");
    a_pf_protected: assert property (prog_ok && target_protected |=> pf_q && state_q == FSS_HALT)
        else $error("protected program did not flag");
    a_ef_bulk_skip: assert property (op_end && state_q == FSS_BULK && bulk_prot_seen |=> !ef_q || $past(ef_q))
        else $error("bulk erase skip set erase flag");
    a_flag_sticky: assert property (pf_q && !clr_ok && !rst_ok |=> pf_q)
        else $error("program flag dropped without clear");
    a_bulk_guard: assert property (go && is_bulk && guard_q != 3'h0 |=> !bst_q && $stable(wpl_q))
        else $error("bulk erase ran with guards set");
    a_wpl_set_cmd: assert property (wpset_ok |=> wpl_q ##1 stat_q[`FSS_BIT_WPL])
        else $error("permit latch not set and shown");
    a_no_permit: assert property (go && !wpl_q && (is_prog || is_regw) |=> !pst_q && state_q == FSS_IDLE)
        else $error("write accepted without permit");
    a_regw_done: assert property (s_regw_finish |=> !wpl_q && state_q == FSS_IDLE)
        else $error("register write did not complete");
    a_fail_busy: assert property (s_fail_seen |-> state_q == FSS_HALT || busy)
        else $error("failure without busy state");
    a_busy_filter: assert property (busy && lk.frame_end && idx_q != 3'h0 && !op_end && !regw_end
        && (cmd_q == `FSS_CMD_WPSET || cmd_q == `FSS_CMD_WPCLR) |=> $stable(wpl_q))
        else $error("permit command accepted while busy");
    a_susp_match: assert property (esp_q |-> $past(state_q) == FSS_ERASE || $past(state_q) == FSS_BULK)
        else $error("erase suspend outside erase");
    a_active_view: assert property (regw_ok |=> ##1 stat_q[`FSS_BIT_ACT] [*2])
        else $error("active flag not shown during write");
endmodule

//--- bench/fss_host_model.sv
`timescale 1ns/1ps
module fss_host_model (
    // Clock
    input  wire logic clock,
    // Serial pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic [7:0] rd_q;
    logic       oe_lo;

    task automatic gap(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Mode 0 frame, bytes left-aligned in tx; the last byte seen on so stays in rd_q
    // oe_lo marks a rising edge at which so was not driven
    task automatic frame(input logic [39:0] tx, input int nb);
        int i;
        cs_n = 1'b0;
        oe_lo = 1'b0;
        gap(8);
        for (i = 0; i < nb * 8; i++) begin
            si = tx[39 - i];
            gap(8);
            sck = 1'b1;
            // An undriven pin reads back inverted so a stale bit cannot pass
            rd_q = {rd_q[6:0], so_oe ? so : ~so};
            oe_lo = oe_lo | ~so_oe;
            gap(8);
            sck = 1'b0;
        end
        // Inverted so that a stale data bit can never pass for a driven one
        si = ~si;
        cs_n = 1'b1;
        gap(16);
    endtask

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rd_q = 8'h00;
        oe_lo = 1'b0;
    end
endmodule

//--- bench/test_fss_status_ctrl.sv
`timescale 1ns/1ps
module test_fss_status_ctrl;
    import fss_pkg::*;

    typedef struct {
        logic [39:0] tx;
        int          nb;
        logic        wp_n;
        fss_byte_t   exp;
    } fss_row_t;

    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        sck;
    logic        cs_n;
    logic        si;
    logic        wr_protect_n = 1'b1;
    logic        gvs = 1'b1;
    logic        lpb = 1'b0;
    logic        tprot = 1'b0;
    logic        op_done = 1'b0;
    logic        op_fail = 1'b0;
    logic        bprot = 1'b0;
    logic        so;
    logic        so_oe;
    wire  [5:0]  pulses;
    logic [23:0] op_addr;
    fss_byte_t   status;
    int          n_pulse [6] = '{default: 0};
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_cyc = 0;
    fss_row_t    rows [10];

    always #5 clock = ~clock;

    fss_status_ctrl #(.REGW_CYCLES(5)) dut_u (
        .clock(clock), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .wr_protect_n(wr_protect_n),
        .so(so), .so_oe(so_oe), .guard_volatility_select(gvs), .lock_protection_bit(lpb),
        .target_protected(tprot), .op_done(op_done), .op_fail(op_fail), .bulk_prot_seen(bprot),
        .prog_start(pulses[0]), .erase_start(pulses[1]), .bulk_start(pulses[2]),
        .erase_suspend(pulses[3]), .prog_suspend(pulses[4]), .soft_reset(pulses[5]),
        .op_addr(op_addr), .flash_status_one(status)
    );

    fss_host_model host_u (.clock(clock), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    // Pulses are one cycle wide, so counting them proves both presence and count
    always @(posedge clock) begin
        for (int k = 0; k < 6; k++) begin
            if (pulses[k] === 1'b1)
                n_pulse[k]++;
        end
    end

    always @(posedge clock) begin
        n_cyc++;
        if (n_cyc == 60000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic fr(input logic [39:0] tx, input int nb, input fss_byte_t exp);
        host_u.frame(tx, nb);
        chk("status", {16'h0, status}, {16'h0, exp});
    endtask

    task automatic done_pulse(input logic f, input logic b);
        @(posedge clock);
        #1;
        op_fail = f;
        bprot = b;
        op_done = 1'b1;
        @(posedge clock);
        #1;
        op_done = 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic hold_reset;
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("reset status", {16'h0, status}, 24'h0);
        nrst = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chk("guard default", {16'h0, status}, 24'h1C);
    endtask

    initial begin
        rows = '{
            '{40'h0600000000, 1, 1'b1, 8'h1E},
            '{40'h0400000000, 1, 1'b1, 8'h1C},
            '{40'h0100000000, 2, 1'b1, 8'h1C},
            '{40'h0600000000, 1, 1'b1, 8'h1E},
            '{40'h0180000000, 2, 1'b1, 8'h80},
            '{40'h0600000000, 1, 1'b1, 8'h82},
            '{40'h011C000000, 2, 1'b0, 8'h82},
            '{40'h010C000000, 2, 1'b1, 8'h0C},
            '{40'h0600000000, 1, 1'b1, 8'h0E},
            '{40'h6000000000, 1, 1'b1, 8'h0E}
        };
        hold_reset();
        foreach (rows[i]) begin
            wr_protect_n = rows[i].wp_n;
            fr(rows[i].tx, rows[i].nb, rows[i].exp);
        end
        fr(40'h0100000000, 2, 8'h00);
        // Protected program: flag set, device stays busy until cleared
        fr(40'h0600000000, 1, 8'h02);
        tprot = 1'b1;
        fr(40'h02123456AA, 5, 8'h43);
        chk("prog start", 24'(n_pulse[0]), 24'd0);
        fr(40'h0400000000, 1, 8'h43);
        fr(40'h0500000000, 2, 8'h43);
        chk("status read", {16'h0, host_u.rd_q}, 24'h43);
        chk("so driven", {23'h0, host_u.oe_lo}, 24'h0);
        chk("so released", {23'h0, so_oe}, 24'h0);
        fr(40'h3000000000, 1, 8'h02);
        fr(40'h0400000000, 1, 8'h00);
        // Successful program
        tprot = 1'b0;
        fr(40'h0600000000, 1, 8'h02);
        fr(40'h02123456AA, 5, 8'h03);
        chk("address", op_addr, 24'h123456);
        chk("prog start", 24'(n_pulse[0]), 24'd1);
        done_pulse(1'b0, 1'b0);
        chk("after program", {16'h0, status}, 24'h0);
        // Failing program, with a second status read and a suspend on the way
        fr(40'h0600000000, 1, 8'h02);
        fr(40'h02123456AA, 5, 8'h03);
        fr(40'h0700000000, 2, 8'h03);
        host_u.frame(40'h8500000000, 1);
        chk("prog suspend", 24'(n_pulse[4]), 24'd1);
        done_pulse(1'b1, 1'b0);
        chk("prog fail", {16'h0, status}, 24'h43);
        fr(40'h3000000000, 1, 8'h02);
        fr(40'h0400000000, 1, 8'h00);
        // Protected sector erase, then bulk erase over a protected sector
        fr(40'h0600000000, 1, 8'h02);
        tprot = 1'b1;
        fr(40'hD812345600, 4, 8'h23);
        tprot = 1'b0;
        fr(40'h3000000000, 1, 8'h02);
        fr(40'h6000000000, 1, 8'h03);
        chk("bulk start", 24'(n_pulse[2]), 24'd1);
        done_pulse(1'b1, 1'b1);
        chk("after bulk", {16'h0, status}, 24'h02);
        // Failing erase keeps the device busy
        fr(40'hD812345600, 4, 8'h03);
        done_pulse(1'b1, 1'b0);
        chk("erase fail", {16'h0, status}, 24'h23);
        fr(40'h3000000000, 1, 8'h02);
        // Suspends only for the matching operation, then software reset
        fr(40'hD812345600, 4, 8'h03);
        chk("erase start", 24'(n_pulse[1]), 24'd2);
        fr(40'h8500000000, 1, 8'h03);
        chk("prog suspend", 24'(n_pulse[4]), 24'd1);
        host_u.frame(40'h7500000000, 1);
        chk("erase suspend", 24'(n_pulse[3]), 24'd1);
        fr(40'hF000000000, 1, 8'h1C);
        chk("soft reset", 24'(n_pulse[5]), 24'd1);
        // Lock protection freezes the guards
        lpb = 1'b1;
        fr(40'h0600000000, 1, 8'h1E);
        fr(40'h0100000000, 2, 8'h1C);
        lpb = 1'b0;
        fr(40'h0600000000, 1, 8'h1E);
        // Non-volatile guards survive a software reset
        gvs = 1'b0;
        fr(40'h0108000000, 2, 8'h08);
        fr(40'hF000000000, 1, 8'h08);
        chk("soft reset", 24'(n_pulse[5]), 24'd2);
        gvs = 1'b1;
        hold_reset();
        wrap_up();
    end
endmodule
